// ### dci_cp_bank.sv
// Per-channel device and software completion pointers of one direction
`include "dci_map.svh"
module dci_cp_bank #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pointer port
  dci_cp_if.bank   cp
);
  import dci_pkg::*;
  localparam int CW = $clog2(NCH);
  dci_addr_t hw_ptr_ff [NCH];
  dci_addr_t sw_ptr_ff [NCH];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hw_ptr_ff[i] <= `DCI_CP_RST;
      end else if (cp.hw_done && cp.hw_chan == CW'(i)) begin
        hw_ptr_ff[i] <= cp.hw_addr; // [R11]
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sw_ptr_ff[i] <= `DCI_CP_RST;
      end else if (cp.sw_wr && cp.sw_chan == CW'(i)) begin
        sw_ptr_ff[i] <= cp.sw_data; // [R3]
      end
    end
    assign cp.raw[i] = hw_ptr_ff[i] != sw_ptr_ff[i]; // [R3]
  end

  assign cp.rd_ptr = hw_ptr_ff[cp.rd_chan]; // [R2]

  a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    cp.sw_wr && !cp.hw_done && cp.sw_data == hw_ptr_ff[cp.sw_chan]
    |=> !cp.raw[$past(cp.sw_chan)])
    else $error("acknowledge did not clear channel interrupt");
  a_done_records: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    cp.hw_done |=> hw_ptr_ff[$past(cp.hw_chan)] == $past(cp.hw_addr))
    else $error("completed descriptor address not recorded");
endmodule

// ### dci_cp_if.sv
// Completion pointer bank connection
interface dci_cp_if #(parameter int NCH = 8) ();
  localparam int CW = $clog2(NCH);
  logic              sw_wr;
  logic [CW-1:0]     sw_chan;
  dci_pkg::dci_addr_t sw_data;
  logic              hw_done;
  logic [CW-1:0]     hw_chan;
  dci_pkg::dci_addr_t hw_addr;
  logic [CW-1:0]     rd_chan;
  dci_pkg::dci_addr_t rd_ptr;
  logic [NCH-1:0]    raw;
  modport bank (input sw_wr, sw_chan, sw_data, hw_done, hw_chan, hw_addr, rd_chan,
                output rd_ptr, raw);
  modport ctrl (output sw_wr, sw_chan, sw_data, hw_done, hw_chan, hw_addr, rd_chan,
                input rd_ptr, raw);
endinterface

// ### dci_desc_check.sv
// Descriptor alignment check and end-of-queue marking
`include "dci_map.svh"
module dci_desc_check (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Completion from the DMA
  input  wire logic         done_valid,
  input  dci_pkg::dci_addr_t done_addr,
  input  dci_pkg::dci_addr_t done_next,
  input  wire logic         done_eop,
  // End-of-queue flag write
  output logic              qend_wr_valid,
  output dci_pkg::dci_addr_t qend_wr_addr,
  // Events
  output logic              align_evt
);
  import dci_pkg::*;
  logic      misalign;
  logic      mark_qend;
  logic      qend_ff;
  logic      align_ff;
  dci_addr_t qend_addr_ff;

  assign misalign = done_valid && (((done_addr & `DCI_ALIGN_MASK) != '0) ||
                    ((done_next & `DCI_ALIGN_MASK) != '0)); // [R8]
  assign mark_qend = done_valid && done_eop && done_next == '0 && !misalign; // [R9] [R10]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qend_ff  <= 1'b0;
      align_ff <= 1'b0;
    end else begin
      qend_ff  <= mark_qend;
      align_ff <= misalign;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qend_addr_ff <= `DCI_CP_RST;
    end else if (mark_qend) begin
      qend_addr_ff <= done_addr + `DCI_FLAGS_OFS; // [R8] [R10]
    end
  end
  assign qend_wr_valid = qend_ff;
  assign qend_wr_addr  = qend_addr_ff;
  assign align_evt     = align_ff;

  a_qend_strobe: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    done_valid && done_eop && done_next == '0 && (done_addr & `DCI_ALIGN_MASK) == '0
    |=> qend_wr_valid && qend_wr_addr == $past(done_addr) + `DCI_FLAGS_OFS)
    else $error("end-of-queue flag not written");
  a_align_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    done_valid && (done_addr & `DCI_ALIGN_MASK) != '0 |=> align_evt && !qend_wr_valid)
    else $error("misaligned descriptor not flagged");
endmodule

// ### dci_map.svh
// Register offsets, field positions and reset values of the completion interrupt block
`ifndef DCI_MAP_SVH
`define DCI_MAP_SVH
`define DCI_NCH         8
`define DCI_TXCP_BASE   8'h00
`define DCI_RXCP_BASE   8'h20
`define DCI_TXRAW       8'h40
`define DCI_RXRAW       8'h44
`define DCI_TXMSK_SET   8'h48
`define DCI_TXMSK_CLR   8'h4c
`define DCI_RXMSK_SET   8'h50
`define DCI_RXMSK_CLR   8'h54
`define DCI_TXMASKED    8'h58
`define DCI_RXMASKED    8'h5c
`define DCI_CTRL        8'h60
`define DCI_EVT_STAT    8'h64
`define DCI_EVT_MASK    8'h68
`define DCI_CTRL_GEN    0
`define DCI_EVT_QEND    0
`define DCI_EVT_ALIGN   1
`define DCI_EVT_W       2
`define DCI_CP_RST      32'h00000000
`define DCI_MSK_RST     8'h00
`define DCI_EVT_RST     2'h0
`define DCI_FLAGS_OFS   32'h0000000c
`define DCI_ALIGN_MASK  32'h00000003
`endif

// ### dci_pkg.sv
// Types shared by the completion interrupt block
package dci_pkg;
  typedef logic [31:0] dci_addr_t;
  typedef logic [31:0] dci_data_t;
  typedef logic [7:0]  dci_paddr_t;
endpackage

// ### dci_top.sv
// Descriptor completion interrupt controller with APB registers
// Function
// R1: Eight transmit and eight receive completion pointers, each also the acknowledge.
// R2: Reading a completion pointer returns the last descriptor the device finished.
// R3: Writes record software's pointer; interrupt stays up while the two differ.
// R4: Software acknowledges by writing back the exact pointer the device holds.
// R5: A channel reaches the output only when set in its mask register.
// R6: Combined MAC and management interrupt leaves only while global enable is set.
// R7: Raw status registers show every channel's state regardless of masking.
// R8: Descriptors are four aligned 32-bit words, one packet or fragment each.
// R9: First word links the next descriptor; zero ends the list.
// R10: Last descriptor with zero next link gets its end-of-queue flag set.
// R11: Each completed descriptor updates that channel's device pointer.
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "dci_map.svh"
module dci_top #(
  parameter int NCH = `DCI_NCH
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  dci_pkg::dci_paddr_t paddr,
  input  dci_pkg::dci_data_t pwdata,
  output dci_pkg::dci_data_t prdata,
  output logic               pready,
  output logic               pslverr,
  // Descriptor completion from the DMA
  input  wire logic          done_valid,
  input  wire logic          done_is_rx,
  input  wire logic [2:0]    done_chan,
  input  dci_pkg::dci_addr_t done_addr,
  input  dci_pkg::dci_addr_t done_next,
  input  wire logic          done_eop,
  // End-of-queue flag write to memory
  output logic               qend_wr_valid,
  output dci_pkg::dci_addr_t qend_wr_addr,
  // Management unit interrupt
  input  wire logic          mgmt_irq,
  // Processor interrupt
  output logic               irq
);
  import dci_pkg::*;
  localparam int CW = $clog2(NCH);

  dci_cp_if #(.NCH(NCH)) tx_cp ();
  dci_cp_if #(.NCH(NCH)) rx_cp ();

  logic                  setup;
  logic                  acc;
  logic                  wr_acc;
  logic                  a_ok;
  logic                  in_txcp;
  logic                  in_rxcp;
  logic                  align_evt;
  logic [NCH-1:0]        tx_mask_ff;
  logic [NCH-1:0]        rx_mask_ff;
  logic [NCH-1:0]        tx_masked;
  logic [NCH-1:0]        rx_masked;
  logic                  gen_ff;
  logic [`DCI_EVT_W-1:0] evt_stat_ff;
  logic [`DCI_EVT_W-1:0] evt_mask_ff;
  logic [`DCI_EVT_W-1:0] evt_set;
  logic [`DCI_EVT_W-1:0] evt_clr;
  logic                  irq_ff;
  logic                  nxt_irq;
  dci_data_t             prdata_ff;
  dci_data_t             nxt_rdata;
  logic                  slverr_ff;
  logic                  nxt_err;

  // Bus phases
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr_acc  = acc && pwrite;
  assign a_ok    = paddr[1:0] == 2'h0;
  assign in_txcp = a_ok && paddr[7:5] == 3'(`DCI_TXCP_BASE >> 5); // [R1]
  assign in_rxcp = a_ok && paddr[7:5] == 3'(`DCI_RXCP_BASE >> 5); // [R1]
  assign pready  = 1'b1;
  assign pslverr = slverr_ff && acc;
  assign prdata  = prdata_ff;

  // Transmit pointer bank connection
  assign tx_cp.sw_wr   = wr_acc && in_txcp; // [R1] [R3]
  assign tx_cp.sw_chan = paddr[CW+1:2];
  assign tx_cp.sw_data = pwdata;
  assign tx_cp.hw_done = done_valid && !done_is_rx; // [R11]
  assign tx_cp.hw_chan = done_chan[CW-1:0];
  assign tx_cp.hw_addr = done_addr;
  assign tx_cp.rd_chan = paddr[CW+1:2];

  // Receive pointer bank connection
  assign rx_cp.sw_wr   = wr_acc && in_rxcp; // [R1] [R3]
  assign rx_cp.sw_chan = paddr[CW+1:2];
  assign rx_cp.sw_data = pwdata;
  assign rx_cp.hw_done = done_valid && done_is_rx; // [R11]
  assign rx_cp.hw_chan = done_chan[CW-1:0];
  assign rx_cp.hw_addr = done_addr;
  assign rx_cp.rd_chan = paddr[CW+1:2];

  dci_cp_bank #(.NCH(NCH)) u_tx_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .cp      (tx_cp)
  );

  dci_cp_bank #(.NCH(NCH)) u_rx_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .cp      (rx_cp)
  );

  dci_desc_check u_check (
    .pclk          (pclk),
    .presetn       (presetn),
    .done_valid    (done_valid),
    .done_addr     (done_addr),
    .done_next     (done_next),
    .done_eop      (done_eop),
    .qend_wr_valid (qend_wr_valid),
    .qend_wr_addr  (qend_wr_addr),
    .align_evt     (align_evt)
  );

  // Channel gating
  assign tx_masked = tx_cp.raw & tx_mask_ff; // [R5]
  assign rx_masked = rx_cp.raw & rx_mask_ff; // [R5]

  // Transmit mask, set and clear by writing ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mask_ff <= NCH'(`DCI_MSK_RST);
    end else if (wr_acc && paddr == `DCI_TXMSK_SET) begin
      tx_mask_ff <= tx_mask_ff | pwdata[NCH-1:0]; // [R5]
    end else if (wr_acc && paddr == `DCI_TXMSK_CLR) begin
      tx_mask_ff <= tx_mask_ff & ~pwdata[NCH-1:0];
    end
  end

  a_txmsk_set: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    wr_acc && paddr == `DCI_TXMSK_SET
    |=> (tx_mask_ff & $past(pwdata[NCH-1:0])) == $past(pwdata[NCH-1:0]))
    else $error("transmit mask bits not set");
  a_txmsk_clr: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    wr_acc && paddr == `DCI_TXMSK_CLR |=> (tx_mask_ff & $past(pwdata[NCH-1:0])) == '0)
    else $error("transmit mask bits not cleared");
  a_txmsk_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    !(wr_acc && (paddr == `DCI_TXMSK_SET || paddr == `DCI_TXMSK_CLR))
    |=> tx_mask_ff == $past(tx_mask_ff))
    else $error("transmit mask changed without a write");

  // Receive mask, set and clear by writing ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mask_ff <= NCH'(`DCI_MSK_RST);
    end else if (wr_acc && paddr == `DCI_RXMSK_SET) begin
      rx_mask_ff <= rx_mask_ff | pwdata[NCH-1:0]; // [R5]
    end else if (wr_acc && paddr == `DCI_RXMSK_CLR) begin
      rx_mask_ff <= rx_mask_ff & ~pwdata[NCH-1:0];
    end
  end

  a_rxmsk_set: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    wr_acc && paddr == `DCI_RXMSK_SET
    |=> (rx_mask_ff & $past(pwdata[NCH-1:0])) == $past(pwdata[NCH-1:0]))
    else $error("receive mask bits not set");
  a_rxmsk_clr: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    wr_acc && paddr == `DCI_RXMSK_CLR |=> (rx_mask_ff & $past(pwdata[NCH-1:0])) == '0)
    else $error("receive mask bits not cleared");
  a_rxmsk_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    !(wr_acc && (paddr == `DCI_RXMSK_SET || paddr == `DCI_RXMSK_CLR))
    |=> rx_mask_ff == $past(rx_mask_ff))
    else $error("receive mask changed without a write");

  // Global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_ff <= 1'b0;
    end else if (wr_acc && paddr == `DCI_CTRL) begin
      gen_ff <= pwdata[`DCI_CTRL_GEN]; // [R6]
    end
  end

  a_gen_write: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    wr_acc && paddr == `DCI_CTRL |=> gen_ff == $past(pwdata[`DCI_CTRL_GEN]))
    else $error("global enable write not taken");
  a_gen_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    !(wr_acc && paddr == `DCI_CTRL) |=> gen_ff == $past(gen_ff))
    else $error("global enable changed without a write");

  // Sticky events, a new event beats a clear
  assign evt_set[`DCI_EVT_QEND]  = qend_wr_valid;
  assign evt_set[`DCI_EVT_ALIGN] = align_evt;
  assign evt_clr = (wr_acc && paddr == `DCI_EVT_STAT) ? pwdata[`DCI_EVT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_ff <= `DCI_EVT_RST;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_ff <= `DCI_EVT_RST;
    end else if (wr_acc && paddr == `DCI_EVT_MASK) begin
      evt_mask_ff <= pwdata[`DCI_EVT_W-1:0];
    end
  end

  a_evt_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    evt_clr == '0 |=> (evt_stat_ff & $past(evt_stat_ff)) == $past(evt_stat_ff))
    else $error("event status bit dropped without a clear");
  a_evt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    evt_set == '0 |=> (evt_stat_ff & $past(evt_clr)) == '0)
    else $error("event status bit not cleared");
  a_align_sticky: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    align_evt |=> evt_stat_ff[`DCI_EVT_ALIGN])
    else $error("misaligned descriptor event not recorded");
  a_qend_sticky: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    qend_wr_valid |=> evt_stat_ff[`DCI_EVT_QEND])
    else $error("end-of-queue event not recorded");
  a_evt_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `DCI_EVT_MASK |=> evt_mask_ff == $past(pwdata[`DCI_EVT_W-1:0]))
    else $error("event mask write not taken");

  // Combined interrupt
  assign nxt_irq = gen_ff && ((|tx_masked) || (|rx_masked) ||
                   (|(evt_stat_ff & evt_mask_ff)) || mgmt_irq); // [R5] [R6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end
  assign irq = irq_ff;

  a_rx_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    gen_ff && (rx_cp.raw & rx_mask_ff) != '0 |=> irq)
    else $error("enabled receive channel interrupt not forwarded");
  a_mgmt_pass: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    gen_ff && mgmt_irq |=> irq)
    else $error("management interrupt not forwarded");
  a_evt_pass: assert property (@(posedge pclk) disable iff (!presetn)
    gen_ff && (evt_stat_ff & evt_mask_ff) != '0 |=> irq)
    else $error("enabled event not forwarded");
  a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
    !gen_ff || (tx_masked == '0 && rx_masked == '0 && (evt_stat_ff & evt_mask_ff) == '0
    && !mgmt_irq) |=> !irq)
    else $error("interrupt raised without an enabled cause");

  // Read data and error decode
  always_comb begin
    nxt_rdata = '0;
    nxt_err   = 1'b0;
    if (in_txcp) begin
      nxt_rdata = tx_cp.rd_ptr; // [R2]
    end else if (in_rxcp) begin
      nxt_rdata = rx_cp.rd_ptr; // [R2]
    end else begin
      unique case (paddr)
        `DCI_TXRAW:     nxt_rdata = 32'(tx_cp.raw); // [R7]
        `DCI_RXRAW:     nxt_rdata = 32'(rx_cp.raw); // [R7]
        `DCI_TXMSK_SET: nxt_rdata = 32'(tx_mask_ff);
        `DCI_TXMSK_CLR: nxt_rdata = 32'(tx_mask_ff);
        `DCI_RXMSK_SET: nxt_rdata = 32'(rx_mask_ff);
        `DCI_RXMSK_CLR: nxt_rdata = 32'(rx_mask_ff);
        `DCI_TXMASKED:  nxt_rdata = 32'(tx_masked);
        `DCI_RXMASKED:  nxt_rdata = 32'(rx_masked);
        `DCI_CTRL:      nxt_rdata = 32'(gen_ff);
        `DCI_EVT_STAT:  nxt_rdata = 32'(evt_stat_ff);
        `DCI_EVT_MASK:  nxt_rdata = 32'(evt_mask_ff);
        default:        nxt_err   = 1'b1;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? '0 : nxt_rdata;
      slverr_ff <= nxt_err;
    end
  end

  // Checks
  a_cp_read: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    setup && !pwrite && in_txcp |=> prdata == $past(tx_cp.rd_ptr))
    else $error("completion pointer read returned wrong value");
  a_raw_read: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    setup && !pwrite && paddr == `DCI_RXRAW |=> prdata == 32'($past(rx_cp.raw)))
    else $error("raw status read differs from channel state");
  a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    gen_ff && (tx_cp.raw & tx_mask_ff) != '0 |=> irq)
    else $error("enabled channel interrupt not forwarded");
  a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    tx_mask_ff == '0 && rx_mask_ff == '0 && evt_mask_ff == '0 && !mgmt_irq |=> !irq)
    else $error("interrupt raised with every source masked");
  a_global_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    !gen_ff |=> !irq)
    else $error("interrupt raised while globally disabled");
  a_evt_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    qend_wr_valid && evt_clr[`DCI_EVT_QEND] |=> evt_stat_ff[`DCI_EVT_QEND])
    else $error("end-of-queue event lost to clear");
  a_cp_ack_cycle: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    wr_acc && in_rxcp && !done_valid && pwdata != rx_cp.rd_ptr
    && paddr[CW+1:2] == rx_cp.rd_chan |=> rx_cp.raw[$past(paddr[CW+1:2])])
    else $error("pointer mismatch did not raise channel interrupt");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !a_ok ##1 acc |-> pslverr)
    else $error("unaligned access not answered with error");
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    setup && (in_txcp || in_rxcp) ##1 acc |-> !pslverr)
    else $error("completion pointer access answered with error");
  a_bad_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && !a_ok |=> prdata == '0)
    else $error("unaligned read returned nonzero data");
  a_write_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    setup && pwrite |=> prdata == '0)
    else $error("write returned nonzero read data");
  a_rxcp_read: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    setup && !pwrite && in_rxcp |=> prdata == $past(rx_cp.rd_ptr))
    else $error("receive pointer read returned wrong value");
  a_txraw_read: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    setup && !pwrite && paddr == `DCI_TXRAW |=> prdata == 32'($past(tx_cp.raw)))
    else $error("transmit raw status read differs from channel state");
  a_txmasked_read: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    setup && !pwrite && paddr == `DCI_TXMASKED |=> prdata == 32'($past(tx_masked)))
    else $error("transmit masked status read wrong");
  a_rxmasked_read: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    setup && !pwrite && paddr == `DCI_RXMASKED |=> prdata == 32'($past(rx_masked)))
    else $error("receive masked status read wrong");
  a_txcp_mismatch: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    wr_acc && in_txcp && !done_valid && pwdata != tx_cp.rd_ptr
    |=> tx_cp.raw[$past(paddr[CW+1:2])])
    else $error("transmit pointer mismatch did not raise interrupt");
endmodule

// ### descriptor_completion_interrupts_bench.sv
// Self-checking bench of the completion interrupt controller
`include "dci_map.svh"
module descriptor_completion_interrupts_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dci_pkg::*;

  typedef struct {
    logic       wr;
    dci_paddr_t a;
    dci_data_t  d;
    dci_data_t  q;
    logic       e;
  } dci_row_t;

  logic       pclk;
  logic       presetn;
  logic       psel;
  logic       penable;
  logic       pwrite;
  dci_paddr_t paddr;
  dci_data_t  pwdata;
  dci_data_t  prdata;
  dci_data_t  rd;
  logic       pready;
  logic       pslverr;
  logic       err;
  logic       done_valid;
  logic       done_is_rx;
  logic       done_eop;
  logic [2:0] done_chan;
  dci_addr_t  done_addr;
  dci_addr_t  done_next;
  logic       qend_wr_valid;
  dci_addr_t  qend_wr_addr;
  logic       mgmt_irq;
  logic       irq;
  int         failures = 0;
  int         n_compared = 0;
  int         cycles = 0;

  // Register accesses after reset: inputs beside expected read data and error
  dci_row_t rows [26] = '{
    '{1'h0, `DCI_TXCP_BASE, 32'h0, `DCI_CP_RST, 1'h0},
    '{1'h0, `DCI_RXCP_BASE + 8'h1c, 32'h0, `DCI_CP_RST, 1'h0},
    '{1'h0, `DCI_TXRAW, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_RXRAW, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_TXMSK_SET, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_TXMASKED, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_EVT_STAT, 32'h0, 32'h0, 1'h0},
    '{1'h0, `DCI_EVT_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h1, `DCI_TXMSK_SET, 32'h5, 32'h0, 1'h0},
    '{1'h0, `DCI_TXMSK_SET, 32'h0, 32'h5, 1'h0},
    '{1'h1, `DCI_TXMSK_CLR, 32'h1, 32'h0, 1'h0},
    '{1'h0, `DCI_TXMSK_CLR, 32'h0, 32'h4, 1'h0},
    '{1'h1, `DCI_RXMSK_SET, 32'hff, 32'h0, 1'h0},
    '{1'h1, `DCI_RXMSK_CLR, 32'h0f, 32'h0, 1'h0},
    '{1'h0, `DCI_RXMSK_SET, 32'h0, 32'hf0, 1'h0},
    '{1'h0, `DCI_RXMSK_CLR, 32'h0, 32'hf0, 1'h0},
    '{1'h1, `DCI_CTRL, 32'h1, 32'h0, 1'h0},
    '{1'h0, `DCI_CTRL, 32'h0, 32'h1, 1'h0},
    '{1'h1, `DCI_EVT_MASK, 32'h3, 32'h0, 1'h0},
    '{1'h0, `DCI_EVT_MASK, 32'h0, 32'h3, 1'h0},
    '{1'h1, `DCI_TXRAW, 32'hff, 32'h0, 1'h0},
    '{1'h0, `DCI_TXRAW, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h6c, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h02, 32'h1, 32'h0, 1'h1},
    '{1'h0, 8'h01, 32'h0, 32'h0, 1'h1}
  };

  dci_top i_dci_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .done_valid, .done_is_rx, .done_chan, .done_addr, .done_next,
    .done_eop, .qend_wr_valid, .qend_wr_addr, .mgmt_irq, .irq
  );

  task automatic conclude;
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input dci_data_t seen, input dci_data_t exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bit_ck(input logic seen, input logic exp);
    check(dci_data_t'(seen), dci_data_t'(exp));
  endtask

  task automatic tick;
    @(posedge pclk);
    #1;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input dci_paddr_t a, input dci_data_t d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdck(input dci_paddr_t a, input dci_data_t exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wrr(input dci_paddr_t a, input dci_data_t d);
    apb(1'h1, a, d);
  endtask

  // One-cycle completion pulse from the DMA
  task automatic done(input logic rx, input logic [2:0] ch, input dci_addr_t a,
                      input dci_addr_t nx, input logic eop);
    @(posedge pclk);
    done_valid <= 1'h1;
    done_is_rx <= rx;
    done_chan <= ch;
    done_addr <= a;
    done_next <= nx;
    done_eop <= eop;
    @(posedge pclk);
    done_valid <= 1'h0;
  endtask

  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, done_valid, done_is_rx, done_eop, mgmt_irq} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    done_chan = 3'h0;
    done_addr = 32'h0;
    done_next = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check(rd, rows[i].q);
      bit_ck(err, rows[i].e);
    end
    // End of list on a masked-in transmit channel
    done(1'h0, 3'h2, 32'h1000, 32'h0, 1'h1);
    #1;
    bit_ck(qend_wr_valid, 1'h1);
    check(qend_wr_addr, 32'h100c);
    bit_ck(irq, 1'h0);
    tick;
    bit_ck(qend_wr_valid, 1'h0);
    bit_ck(irq, 1'h1);
    rdck(`DCI_TXCP_BASE + 8'h08, 32'h1000);
    rdck(`DCI_TXRAW, 32'h4);
    rdck(`DCI_TXMASKED, 32'h4);
    rdck(`DCI_EVT_STAT, 32'h1);
    wrr(`DCI_TXCP_BASE + 8'h08, 32'h1000);
    rdck(`DCI_TXRAW, 32'h0);
    wrr(`DCI_EVT_STAT, 32'h1);
    tick;
    bit_ck(irq, 1'h0);
    // Linked descriptor on a masked-out receive channel
    done(1'h1, 3'h1, 32'h2004, 32'h3000, 1'h1);
    #1;
    bit_ck(qend_wr_valid, 1'h0);
    tick;
    bit_ck(irq, 1'h0);
    rdck(`DCI_RXRAW, 32'h2);
    rdck(`DCI_RXMASKED, 32'h0);
    wrr(`DCI_RXMSK_SET, 32'h2);
    tick;
    bit_ck(irq, 1'h1);
    wrr(`DCI_CTRL, 32'h0);
    tick;
    bit_ck(irq, 1'h0);
    wrr(`DCI_RXCP_BASE + 8'h04, 32'h2000);
    rdck(`DCI_RXRAW, 32'h2);
    wrr(`DCI_RXCP_BASE + 8'h04, 32'h2004);
    rdck(`DCI_RXRAW, 32'h0);
    mgmt_irq <= 1'h1;
    tick;
    tick;
    bit_ck(irq, 1'h0);
    wrr(`DCI_CTRL, 32'h1);
    tick;
    bit_ck(irq, 1'h1);
    @(posedge pclk);
    mgmt_irq <= 1'h0;
    tick;
    bit_ck(irq, 1'h0);
    // Misaligned descriptor is recorded but never marked
    done(1'h0, 3'h0, 32'h1002, 32'h0, 1'h1);
    #1;
    bit_ck(qend_wr_valid, 1'h0);
    rdck(`DCI_EVT_STAT, 32'h2);
    rdck(`DCI_TXCP_BASE, 32'h1002);
    wrr(`DCI_EVT_STAT, 32'h3);
    wrr(`DCI_TXCP_BASE, 32'h1002);
    // Fragment without end of packet re-raises the acknowledged channel
    done(1'h0, 3'h2, 32'h1010, 32'h0, 1'h0);
    #1;
    bit_ck(qend_wr_valid, 1'h0);
    bit_ck(irq, 1'h0);
    tick;
    bit_ck(irq, 1'h1);
    // Every channel of both directions keeps its own pointer
    for (int i = 0; i < 8; i++) begin
      done(1'h0, 3'(i), 32'h4000 + 32'(16 * i), 32'h0, 1'h1);
      done(1'h1, 3'(i), 32'h5000 + 32'(16 * i), 32'h5100, 1'h0);
    end
    for (int i = 0; i < 8; i++) begin
      rdck(`DCI_TXCP_BASE + 8'(4 * i), 32'h4000 + 32'(16 * i));
      rdck(`DCI_RXCP_BASE + 8'(4 * i), 32'h5000 + 32'(16 * i));
    end
    rdck(`DCI_RXRAW, 32'hff);
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    bit_ck(irq, 1'h0);
    check(prdata, 32'h0);
    check(qend_wr_addr, `DCI_CP_RST);
    bit_ck(qend_wr_valid, 1'h0);
    rdck(`DCI_TXCP_BASE + 8'h04, `DCI_CP_RST);
    rdck(`DCI_TXRAW, 32'h0);
    conclude();
  end
endmodule
